// ===== rtl/asc_consts.svh
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// clock period in ns
`define ASC_CLK_PERIOD_NS 100
// timing figures in ns, slow grade taken so both grades are met
`define ASC_T_READ_CYCLE_NS 25
`define ASC_T_ADDR_ACCESS_NS 25
`define ASC_T_GATE_ACCESS_NS 9
`define ASC_T_ADDR_TO_WEND_NS 17
`define ASC_T_WRITE_PULSE_NS 17
`define ASC_T_DATA_SETUP_NS 10
`define ASC_T_RELEASE_NS 10
// cycle counts: least times round up, at least one cycle
`define ASC_CYC_MIN(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_CYC_ACCESS \
  ((`ASC_CYC_MIN(`ASC_T_ADDR_ACCESS_NS) < 1) ? 1 : `ASC_CYC_MIN(`ASC_T_ADDR_ACCESS_NS))
`define ASC_CYC_WPULSE \
  ((`ASC_CYC_MIN(`ASC_T_WRITE_PULSE_NS) < 1) ? 1 : `ASC_CYC_MIN(`ASC_T_WRITE_PULSE_NS))
`define ASC_CYC_RELEASE \
  ((`ASC_CYC_MIN(`ASC_T_RELEASE_NS) < 1) ? 1 : `ASC_CYC_MIN(`ASC_T_RELEASE_NS))
// widths
`define ASC_ADDR_W 20
`define ASC_DATA_W 32
`define ASC_LANES 4
// idle pin levels, counter width
`define ASC_SEL_IDLE 4'hf
`define ASC_CNT_W 4

`endif

// ===== rtl/asc_pkg.sv
package asc_pkg;
  `include "asc_consts.svh"

  typedef enum logic [2:0] {
    ASC_IDLE = 3'b000,
    ASC_RD_ACC = 3'b001,
    ASC_RD_CAP = 3'b010,
    ASC_WR_PULSE = 3'b011,
    ASC_WR_END = 3'b100,
    ASC_TURN = 3'b101
  } asc_state_e;

  typedef struct packed {
    logic write;
    logic [`ASC_ADDR_W-1:0] addr;
    logic [`ASC_LANES-1:0] lanes;
    logic [`ASC_DATA_W-1:0] wdata;
  } asc_req_s;

  typedef struct packed {
    logic [`ASC_ADDR_W-1:0] word_address;
    logic [`ASC_LANES-1:0] byte_select_n;
    logic write_strobe_n;
    logic drive_gate_n;
  } asc_pins_s;
endpackage

// ===== rtl/asc_sync.sv
`timescale 1ns/1ps
module asc_sync #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // three stages; a bit changes once stages two and three agree
  logic [W-1:0] s1_reg, s2_reg, s3_reg, out_reg;
  logic [W-1:0] out_next;

  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule

// ===== rtl/asc_ctrl.sv
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_ctrl
  import asc_pkg::*;
#(
  parameter int ADDR_W = `ASC_ADDR_W,
  parameter int DATA_W = `ASC_DATA_W,
  parameter int LANES = `ASC_LANES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // user request
  input wire logic req_valid,
  input wire asc_pkg::asc_req_s req,
  output logic req_ready,
  // user answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  // memory pins
  output asc_pkg::asc_pins_s mem_pins,
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic [DATA_W-1:0] data_lines_oe
);
  import asc_pkg::*;

  // ==========================================================
  // cycle counts
  localparam logic [`ASC_CNT_W-1:0] CYC_ACCESS = `ASC_CNT_W'(`ASC_CYC_ACCESS);
  localparam logic [`ASC_CNT_W-1:0] CYC_WPULSE = `ASC_CNT_W'(`ASC_CYC_WPULSE);
  localparam logic [`ASC_CNT_W-1:0] CYC_RELEASE = `ASC_CNT_W'(`ASC_CYC_RELEASE);

  // ==========================================================
  // data input synchroniser
  logic [DATA_W-1:0] rd_sync;

  asc_sync #(.W(DATA_W)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(data_lines_in),
    .dout(rd_sync)
  );

  // ==========================================================
  // sequencer state
  asc_state_e state_reg, state_next;
  logic [`ASC_CNT_W-1:0] cnt_reg, cnt_next;
  asc_pins_s pins_reg, pins_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic [DATA_W-1:0] oe_reg, oe_next;
  logic ready_reg, ready_next;
  logic rvalid_reg, rvalid_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [DATA_W-1:0] lane_mask;

  // ==========================================================
  // lane mask
  // one mask bit per data line from its lane select
  genvar g;
  generate
    for (g = 0; g < DATA_W; g++) begin : g_mask
      assign lane_mask[g] = req.lanes[g / (DATA_W / LANES)];
    end
  endgenerate

  // ==========================================================
  // next-state logic
  // one next-value block for the whole sequencer
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pins_next = pins_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    ready_next = 1'b0;
    rvalid_next = 1'b0;
    rdata_next = rdata_reg;
    case (state_reg)
      ASC_IDLE: begin
        ready_next = 1'b1;
        if (req_valid && ready_reg) begin
          ready_next = 1'b0;
          // address placed with selects in same edge: setup 0 ns
          pins_next.word_address = req.addr;
          pins_next.byte_select_n = ~req.lanes;
          if (req.write) begin
            // strobe, selects and data all change on one edge
            pins_next.write_strobe_n = 1'b0;
            pins_next.drive_gate_n = 1'b1;
            dout_next = req.wdata;
            oe_next = lane_mask;
            cnt_next = CYC_WPULSE;
            state_next = ASC_WR_PULSE;
          end else begin
            pins_next.write_strobe_n = 1'b1;
            // own drivers already off in idle, before gate falls
            pins_next.drive_gate_n = 1'b0;
            oe_next = '0;
            // access plus the three-stage input delay
            cnt_next = CYC_ACCESS + `ASC_CNT_W'(3);
            state_next = ASC_RD_ACC;
          end
        end
      end

      ASC_RD_ACC: begin
        // address and selects hold while data crosses the input flops
        if (cnt_reg <= `ASC_CNT_W'(1)) begin
          state_next = ASC_RD_CAP;
        end else begin
          cnt_next = cnt_reg - `ASC_CNT_W'(1);
        end
      end

      ASC_RD_CAP: begin
        // address held for the full access time: read cycle met
        rdata_next = rd_sync;
        rvalid_next = 1'b1;
        pins_next.byte_select_n = `ASC_SEL_IDLE;
        pins_next.drive_gate_n = 1'b1;
        cnt_next = CYC_RELEASE;
        state_next = ASC_TURN;
      end

      ASC_WR_PULSE: begin
        // strobe stays low for the whole count
        if (cnt_reg <= `ASC_CNT_W'(1)) begin
          state_next = ASC_WR_END;
        end else begin
          cnt_next = cnt_reg - `ASC_CNT_W'(1);
        end
      end

      ASC_WR_END: begin
        // strobe and selects rise together; address and data stay
        pins_next.write_strobe_n = 1'b1;
        pins_next.byte_select_n = `ASC_SEL_IDLE;
        cnt_next = CYC_RELEASE;
        state_next = ASC_TURN;
      end

      ASC_TURN: begin
        // hold data one cycle past write end, wait for device float
        oe_next = '0;
        if (cnt_reg <= `ASC_CNT_W'(1)) begin
          ready_next = 1'b1;
          state_next = ASC_IDLE;
        end else begin
          cnt_next = cnt_reg - `ASC_CNT_W'(1);
        end
      end

      default: begin
        state_next = ASC_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ASC_IDLE;
      cnt_reg <= '0;
      // pins idle: nothing selected, no strobe, no drive gate
      pins_reg.word_address <= '0;
      pins_reg.byte_select_n <= `ASC_SEL_IDLE;
      pins_reg.write_strobe_n <= 1'b1;
      pins_reg.drive_gate_n <= 1'b1;
      dout_reg <= '0;
      oe_reg <= '0;
      // first take comes two edges after reset ends
      ready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      pins_reg <= pins_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      ready_reg <= ready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // outputs
  assign req_ready = ready_reg;
  assign rsp_valid = rvalid_reg;
  assign rsp_rdata = rdata_reg;
  assign mem_pins = pins_reg;
  assign data_lines_out = dout_reg;
  assign data_lines_oe = oe_reg;
endmodule

// ===== bench/asc_sram_model.sv
`timescale 1ns/1ps
// ========
// far-side memory
module asc_sram_model
  import asc_pkg::*;
#(
  parameter int RD_DLY = 25
) (
  // memory pins
  input wire asc_pkg::asc_pins_s pins,
  input wire logic [31:0] din,
  output logic [31:0] q
);
  logic [31:0] mem [0:(1<<20)-1];
  logic [31:0] qd;
  logic drv;
  assign #RD_DLY qd = mem[pins.word_address];
  always @* begin
    for (int i = 0; i < 4; i++) begin
      if (!pins.write_strobe_n && !pins.byte_select_n[i]) begin
        mem[pins.word_address][8*i+:8] = din[8*i+:8];
      end
    end
  end
  // floated lane shows inverted data at once
  always @* begin
    for (int i = 0; i < 4; i++) begin
      drv = !pins.byte_select_n[i] && pins.write_strobe_n && !pins.drive_gate_n;
      q[8*i+:8] = drv ? qd[8*i+:8] : ~qd[8*i+:8];
    end
  end
endmodule

// ===== bench/asc_ctrl_properties.sv
`timescale 1ns/1ps
// ========
// pin timing checks
module asc_ctrl_properties
  import asc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // user side
  input wire logic req_valid,
  input wire asc_pkg::asc_req_s req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [31:0] rsp_rdata,
  // memory side
  input wire asc_pkg::asc_pins_s mem_pins,
  input wire logic [31:0] data_lines_in,
  input wire logic [31:0] data_lines_out,
  input wire logic [31:0] data_lines_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire ws = mem_pins.write_strobe_n;
  wire gn = mem_pins.drive_gate_n;
  wire tk = req_valid && req_ready;
  wire [31:0] sel_bits = {{8{!mem_pins.byte_select_n[3]}}, {8{!mem_pins.byte_select_n[2]}},
    {8{!mem_pins.byte_select_n[1]}}, {8{!mem_pins.byte_select_n[0]}}};
  property p_rd_strobe; !gn |-> ws; endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("strobe low in read");
  property p_no_contend; !gn |-> data_lines_oe == '0; endproperty
  a_no_contend: assert property (p_no_contend) else $error("drive in read");
  property p_wr_pulse; $fell(ws) |-> !ws [*2] ##1 ws; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("strobe width");
  property p_wr_hold;
    !ws && !$fell(ws) |-> $stable(mem_pins.word_address) && $stable(data_lines_out);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write moved");
  property p_wr_data;
    !ws || $rose(ws) |-> (data_lines_oe & $past(sel_bits)) == $past(sel_bits);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data off");
  property p_wr_take;
    tk && req.write |=> !ws && mem_pins.byte_select_n == ~$past(req.lanes)
      && mem_pins.word_address == $past(req.addr);
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write pins");
  property p_rd_take;
    tk && !req.write |=> ws && !gn && mem_pins.byte_select_n == ~$past(req.lanes)
      && mem_pins.word_address == $past(req.addr);
  endproperty
  a_rd_take: assert property (p_rd_take) else $error("read pins");
  property p_rd_len; $fell(gn) |-> !gn [*5] ##1 gn; endproperty
  a_rd_len: assert property (p_rd_len) else $error("read length");
  property p_sel_end; $rose(ws) |-> &mem_pins.byte_select_n; endproperty
  a_sel_end: assert property (p_sel_end) else $error("select late");
  property p_rsp; tk && !req.write |-> ##6 rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
endmodule

bind asc_ctrl asc_ctrl_properties u_chk (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
  .mem_pins(mem_pins), .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
  .data_lines_oe(data_lines_oe));

// ===== bench/test_async_sram_module_rw_cycles.sv
`timescale 1ns/1ps
// ========
// bench top
module test_async_sram_module_rw_cycles;
  import asc_pkg::*;
  logic mclk = 0;
  logic rst_n = 0;
  logic req_valid = 0;
  asc_req_s req = '0;
  logic req_ready, rsp_valid;
  logic [31:0] rsp_rdata, dl_in, dl_out, dl_oe, q;
  asc_pins_s pins;
  logic [31:0] sh [int];
  logic [31:0] exp_q [$];
  logic [31:0] msk_q [$];
  int n_fail = 0;
  int checks = 0;
  always #50 mclk = ~mclk;
  assign dl_in = (dl_oe & dl_out) | (~dl_oe & q);
  asc_ctrl uut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_pins(pins),
    .data_lines_in(dl_in), .data_lines_out(dl_out), .data_lines_oe(dl_oe));
  asc_sram_model u_mem (.pins(pins), .din(dl_in), .q(q));
  task automatic tally_and_finish;
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic issue(input logic w, input logic [19:0] a, input logic [3:0] l,
    input logic [31:0] d);
    logic [31:0] m;
    m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
    @(negedge mclk);
    req_valid = 1;
    req = '{w, a, l, d};
    do @(posedge mclk); while (req_ready !== 1'b1);
    if (w) sh[a] = (sh.exists(a) ? sh[a] : '0) & ~m | d & m;
    else begin
      exp_q.push_back(sh[a]);
      msk_q.push_back(m);
    end
  endtask
  always @(posedge mclk) begin
    if (rst_n && rsp_valid === 1'b1) begin
      checks++;
      if (exp_q.size() == 0 || ((rsp_rdata ^ exp_q[0]) & msk_q[0]) !== '0) begin
        n_fail++;
        $display("[ERR] %0t read data %h", $time, rsp_rdata);
      end
      if (exp_q.size() > 0) begin
        void'(exp_q.pop_front());
        void'(msk_q.pop_front());
      end
    end
  end
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    logic [19:0] a;
    logic [31:0] d;
    void'($urandom(9344));
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst_n = 1;
    for (int i = 0; i < 16; i++) begin
      a = (i == 15) ? 20'hfffff : 20'($urandom);
      d = $urandom;
      issue(1'b1, a, 4'hf, d);
      issue(1'b1, a, 4'(i), ~d);
      issue(1'b0, a, 4'hf, '0);
      issue(1'b0, a, 4'(i), '0);
    end
    issue(1'b1, a, 4'h5, 32'h0);
    @(negedge mclk) rst_n = 0;
    req_valid = 0;
    #1 checks++;
    if (pins !== {20'h0, 4'hf, 2'b11} || dl_oe !== '0) begin
      n_fail++;
      $display("[ERR] %0t pins not idle", $time);
    end
    @(negedge mclk) rst_n = 1;
    issue(1'b0, a, 4'ha, '0);
    @(negedge mclk) req_valid = 0;
    for (int t = 0; t < 20 && exp_q.size() > 0; t++) @(posedge mclk);
    checks++;
    if (exp_q.size() != 0) begin
      n_fail++;
      $display("[ERR] %0t reads unanswered", $time);
    end
    tally_and_finish();
  end
endmodule
